// ### hdl/cpu_clock_generator_owd.sv
// cpu and peripheral clock selection with pll lock and oscillator watchdog
`timescale 1ns/10ps
`include "cpu_clock_generator_owd_params.svh"

module cpu_clock_generator_owd (
    input wire logic clk, // 20 MHz system clock
    input wire logic reset_n, // synchronous reset
    input wire logic [2:0] clockSelectStraps, // strap pins, async
    input wire logic crystalInputPin, // oscillator input, async
    input wire logic pllLockedRaw, // pll lock indication, async
    input wire logic oscWatchdogDisable, // config register bit
    input wire logic idleMode, // cpu idle request
    input wire logic powerDownMode, // power-down request
    output cpu_clock_generator_owd_pkg::clk_status_s clkStatus, // selection
    output logic clockFailIrq // one-cycle interrupt pulse
);
    import cpu_clock_generator_owd_pkg::*;

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    logic [4:0] syncA_q;
    logic [4:0] syncB_q;
    logic xtalDly_q;
    logic lockDly_q;
    logic [2:0] strapSync;
    logic xtalSync;
    logic lockSync;

    // two stages for every pin; only the second stage is read by logic
    always_ff @(posedge clk) begin
        syncA_q <= {pllLockedRaw, crystalInputPin, clockSelectStraps};
        syncB_q <= syncA_q;
    end

    assign strapSync = syncB_q[2:0];
    assign xtalSync = syncB_q[3];
    assign lockSync = syncB_q[4];

    // delayed copies for edge detection
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            xtalDly_q <= 1'b0;
            lockDly_q <= 1'b0;
        end else begin
            xtalDly_q <= xtalSync;
            lockDly_q <= lockSync;
        end
    end

    // ------------------------------------------------------------------
    // strap latch and mode decode
    // ------------------------------------------------------------------
    logic [2:0] strap_q;
    logic pllMode;
    logic directMode;
    logic prescaleMode;
    logic [4:0] factorHalves;

    // follows the pins while reset is low, frozen at release
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            strap_q <= strapSync;
        end
    end

    assign directMode = (strap_q == `CCG_STRAP_DIRECT);
    assign prescaleMode = (strap_q == `CCG_STRAP_PRESCALE);
    assign pllMode = !directMode && !prescaleMode;

    // factor in halves so that 1.5 and 2.5 stay exact
    always_comb begin
        unique case (strap_q)
            `CCG_STRAP_X4: factorHalves = `CCG_HALVES_X4;
            `CCG_STRAP_X3: factorHalves = `CCG_HALVES_X3;
            `CCG_STRAP_X2: factorHalves = `CCG_HALVES_X2;
            `CCG_STRAP_X5: factorHalves = `CCG_HALVES_X5;
            `CCG_STRAP_DIRECT: factorHalves = `CCG_HALVES_X1;
            `CCG_STRAP_X1P5: factorHalves = `CCG_HALVES_X1P5;
            `CCG_STRAP_PRESCALE: factorHalves = `CCG_HALVES_DIV2;
            `CCG_STRAP_X2P5: factorHalves = `CCG_HALVES_X2P5;
        endcase
    end

    // ------------------------------------------------------------------
    // pll base clock model
    // ------------------------------------------------------------------
    logic [`CCG_PLL_DIV_W-1:0] pllDiv_q;
    logic pllTick;
    logic pllOff;
    owd_state_e owdState_q;

    // the pll is only switched off when nothing needs it
    assign pllOff = !pllMode && (owdState_q == OWD_OFF);
    assign pllTick = !pllOff && (pllDiv_q == `CCG_PLL_DIV_W'(`CCG_PLL_DIV - 1));

    // free-running base tick, kept alive for the watchdog
    always_ff @(posedge clk) begin
        if (!reset_n || pllOff || pllTick) begin
            pllDiv_q <= '0;
        end else begin
            pllDiv_q <= pllDiv_q + `CCG_PLL_DIV_W'(1);
        end
    end

    // ------------------------------------------------------------------
    // oscillator watchdog
    // ------------------------------------------------------------------
    logic [`CCG_OWD_W-1:0] owdCnt_q;
    logic xtalEdge;
    logic owdArmed;
    logic owdOverflow;

    assign xtalEdge = xtalSync ^ xtalDly_q;
    // only the direct and prescaler modes rely on the watchdog
    assign owdArmed = !pllMode && (owdState_q == OWD_RUN);
    // an input edge in the same cycle as the last tick still saves it
    assign owdOverflow = owdArmed && pllTick && !xtalEdge &&
                         (owdCnt_q == `CCG_OWD_LIMIT - `CCG_OWD_W'(1));

    // counter clears on every input transition
    always_ff @(posedge clk) begin
        if (!reset_n || !owdArmed || xtalEdge) begin
            owdCnt_q <= '0;
        end else if (pllTick) begin
            owdCnt_q <= owdCnt_q + `CCG_OWD_W'(1);
        end
    end

    // tripped is left only through hardware reset
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            owdState_q <= OWD_RUN;
        end else begin
            unique case (owdState_q)
                OWD_RUN: begin
                    if (owdOverflow) begin
                        owdState_q <= OWD_TRIPPED;
                    end else if (oscWatchdogDisable) begin
                        owdState_q <= OWD_OFF;
                    end
                end
                OWD_OFF: begin
                    if (!oscWatchdogDisable) begin
                        owdState_q <= OWD_RUN;
                    end
                end
                OWD_TRIPPED: owdState_q <= OWD_TRIPPED;
                default: owdState_q <= OWD_RUN;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // lock loss and interrupt
    // ------------------------------------------------------------------
    logic lockLoss;

    // falling lock after reset; a pll that never locked raises nothing
    assign lockLoss = pllMode && lockDly_q && !lockSync;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            clockFailIrq <= 1'b0;
        end else begin
            clockFailIrq <= lockLoss || owdOverflow;
        end
    end

    // ------------------------------------------------------------------
    // clock selection status
    // ------------------------------------------------------------------
    clk_status_s status_d;

    always_comb begin
        status_d.factorHalves = factorHalves;
        status_d.pllOn = !pllOff;
        status_d.pllSyncAllow = 1'b0;
        status_d.pllAtBase = pllMode ? !lockSync : 1'b1;
        status_d.owdTripped = (owdState_q == OWD_TRIPPED);
        status_d.cpuClkRun = !idleMode && !powerDownMode;
        status_d.periphClkRun = !powerDownMode;
        if (pllMode) begin
            status_d.cpuSrc = SRC_PLL;
        end else if (owdState_q == OWD_TRIPPED) begin
            status_d.cpuSrc = SRC_PLL_BASE;
        end else if (directMode) begin
            status_d.cpuSrc = SRC_DIRECT;
        end else begin
            status_d.cpuSrc = SRC_PRESCALE;
        end
    end

    // during reset the pll runs and may chase the input clock
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            clkStatus <= '{cpuSrc: SRC_PLL, factorHalves: `CCG_HALVES_X4,
                           pllOn: 1'b1, pllSyncAllow: 1'b1, pllAtBase: 1'b1,
                           owdTripped: 1'b0, cpuClkRun: 1'b0,
                           periphClkRun: 1'b0};
        end else begin
            clkStatus <= status_d;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_strapHold;
        @(posedge clk) disable iff (!reset_n)
        $past(reset_n) |-> $stable(strap_q);
    endproperty
    a_strapHold: assert property (p_strapHold)
        else $error("strap selection changed outside reset");

    property p_pllEnable;
        @(posedge clk) disable iff (!reset_n)
        pllMode |=> clkStatus.pllOn && clkStatus.cpuSrc == SRC_PLL;
    endproperty
    a_pllEnable: assert property (p_pllEnable)
        else $error("pll not enabled in a multiplier mode");

    property p_syncOnlyReset;
        @(posedge clk)
        $past(reset_n) && reset_n |-> !clkStatus.pllSyncAllow;
    endproperty
    a_syncOnlyReset: assert property (p_syncOnlyReset)
        else $error("pll synchronisation allowed outside reset");

    property p_lockIrq;
        @(posedge clk) disable iff (!reset_n)
        lockLoss |=> clockFailIrq && clkStatus.pllAtBase;
    endproperty
    a_lockIrq: assert property (p_lockIrq)
        else $error("lock loss without interrupt or base fallback");

    property p_prescale;
        @(posedge clk) disable iff (!reset_n)
        prescaleMode && owdState_q != OWD_TRIPPED |=>
            clkStatus.cpuSrc == SRC_PRESCALE && clkStatus.factorHalves == 5'h01;
    endproperty
    a_prescale: assert property (p_prescale)
        else $error("prescaler mode not selected");

    property p_direct;
        @(posedge clk) disable iff (!reset_n)
        directMode && owdState_q != OWD_TRIPPED |=>
            clkStatus.cpuSrc == SRC_DIRECT && clkStatus.factorHalves == 5'h02;
    endproperty
    a_direct: assert property (p_direct)
        else $error("direct drive not selected");

    property p_owdTrip;
        @(posedge clk) disable iff (!reset_n)
        owdOverflow |=> clockFailIrq && owdState_q == OWD_TRIPPED
            ##1 clkStatus.cpuSrc == SRC_PLL_BASE;
    endproperty
    a_owdTrip: assert property (p_owdTrip)
        else $error("watchdog overflow did not switch to pll base clock");

    property p_owdCount;
        @(posedge clk) disable iff (!reset_n)
        owdOverflow |-> owdCnt_q == 5'h0f && !xtalEdge;
    endproperty
    a_owdCount: assert property (p_owdCount)
        else $error("watchdog overflow at wrong count");

    property p_cntClear;
        @(posedge clk) disable iff (!reset_n)
        xtalEdge |=> owdCnt_q == '0;
    endproperty
    a_cntClear: assert property (p_cntClear)
        else $error("watchdog counter not cleared by input transition");

    property p_tripSticky;
        @(posedge clk) disable iff (!reset_n)
        owdState_q == OWD_TRIPPED |=> owdState_q == OWD_TRIPPED
            && clkStatus.cpuSrc == SRC_PLL_BASE;
    endproperty
    a_tripSticky: assert property (p_tripSticky)
        else $error("watchdog switch undone without reset");

    property p_disabled;
        @(posedge clk) disable iff (!reset_n)
        owdState_q == OWD_OFF && !pllMode |=> !clkStatus.pllOn &&
            clkStatus.cpuSrc != SRC_PLL_BASE;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("disabled watchdog left pll on or off the input");

    property p_enabledAfterReset;
        @(posedge clk)
        !reset_n |=> owdState_q == OWD_RUN;
    endproperty
    a_enabledAfterReset: assert property (p_enabledAfterReset)
        else $error("watchdog not enabled after reset");

    property p_idle;
        @(posedge clk) disable iff (!reset_n)
        $past(reset_n) && idleMode && !powerDownMode ##1 reset_n |->
            !clkStatus.cpuClkRun && clkStatus.periphClkRun;
    endproperty
    a_idle: assert property (p_idle)
        else $error("idle mode clock gating wrong");

    property p_powerDown;
        @(posedge clk) disable iff (!reset_n)
        powerDownMode |=> !clkStatus.cpuClkRun && !clkStatus.periphClkRun;
    endproperty
    a_powerDown: assert property (p_powerDown)
        else $error("power-down left a clock running");

endmodule : cpu_clock_generator_owd

// ### common/cpu_clock_generator_owd_params.svh
// constants of the cpu clock generator with oscillator watchdog
//
// Behaviour
// - straps 111 x4, 110 x3, 101 x2, 100 x5, 011 x1, 010 x1.5, 001 /2, 000 x2.5.
// - the pll is enabled for every strap code except 011 and 001.
// - the pll may synchronise to the input clock only during hardware reset.
// - pll lock loss raises the clock-fail interrupt and drops to base frequency.
// - straps 001 feed the cpu from the input clock through a 2:1 prescaler.
// - straps 011 feed the cpu directly from the input clock.
// - in prescaler and direct modes the pll free-runs to clock the watchdog.
// - the watchdog is on after every reset; the disable bit turns it off.
// - the watchdog counter counts pll ticks and clears on each input transition.
// - after 16 ticks without transition, switch cpu to pll base clock and interrupt.
// - after a watchdog switch the pll clock stays until the next hardware reset.
// - with the watchdog disabled in direct and prescaler modes the cpu runs from the input and pll is off.
// - idle stops only the cpu clock; power-down stops both clocks.
`ifndef CPU_CLOCK_GENERATOR_OWD_PARAMS_SVH
`define CPU_CLOCK_GENERATOR_OWD_PARAMS_SVH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CCG_CLK_KHZ 20000
// pll base frequency, somewhere inside its 2 to 5 MHz range
`define CCG_PLL_BASE_KHZ 4000
`define CCG_PLL_DIV (`CCG_CLK_KHZ / `CCG_PLL_BASE_KHZ)
`define CCG_PLL_DIV_W 3
`define CCG_OWD_LIMIT 5'h10
`define CCG_OWD_W 5

// ----------------------------------------------------------------------
// strap codes and cpu factors in halves of the input frequency
// ----------------------------------------------------------------------
`define CCG_STRAP_X4 3'h7
`define CCG_STRAP_X3 3'h6
`define CCG_STRAP_X2 3'h5
`define CCG_STRAP_X5 3'h4
`define CCG_STRAP_DIRECT 3'h3
`define CCG_STRAP_X1P5 3'h2
`define CCG_STRAP_PRESCALE 3'h1
`define CCG_STRAP_X2P5 3'h0
`define CCG_FACTOR_W 5
`define CCG_HALVES_X4 5'h08
`define CCG_HALVES_X3 5'h06
`define CCG_HALVES_X2 5'h04
`define CCG_HALVES_X5 5'h0a
`define CCG_HALVES_X1 5'h02
`define CCG_HALVES_X1P5 5'h03
`define CCG_HALVES_DIV2 5'h01
`define CCG_HALVES_X2P5 5'h05

`endif

// ### common/cpu_clock_generator_owd_pkg.sv
// types of the cpu clock generator with oscillator watchdog
package cpu_clock_generator_owd_pkg;

    typedef enum logic [1:0] {
        SRC_PLL = 2'b00,
        SRC_DIRECT = 2'b01,
        SRC_PRESCALE = 2'b10,
        SRC_PLL_BASE = 2'b11
    } clk_src_e;

    typedef enum logic [1:0] {
        OWD_RUN = 2'b00,
        OWD_OFF = 2'b01,
        OWD_TRIPPED = 2'b10
    } owd_state_e;

    typedef struct packed {
        clk_src_e cpuSrc;
        logic [4:0] factorHalves;
        logic pllOn;
        logic pllSyncAllow;
        logic pllAtBase;
        logic owdTripped;
        logic cpuClkRun;
        logic periphClkRun;
    } clk_status_s;

endpackage : cpu_clock_generator_owd_pkg

// ### dv/crystal_source.sv
// crystal or oscillator source with a simple pll lock indication
`timescale 1ns/10ps

module crystal_source #(
    parameter int HALF = 10,
    parameter int LOCK_CYC = 8
) (
    input wire logic clk, // bench clock
    input wire logic run, // oscillator alive
    output logic xtal, // crystal input level
    output logic lock // pll lock flag
);
    int phase = 0;
    int up = 0;

    initial xtal = 1'b0;
    initial lock = 1'b0;

    // ----
    // oscillator
    // ----
    // a broken crystal freezes at its last level, no clean idle state
    always @(posedge clk) begin
        if (run) begin
            phase <= (phase == HALF - 1) ? 0 : phase + 1;
            if (phase == HALF - 1) xtal <= ~xtal;
        end
    end

    // lock settles after a delay, lost at once when the input dies
    always @(posedge clk) begin
        up <= run ? ((up < LOCK_CYC) ? up + 1 : up) : 0;
        lock <= run && (up >= LOCK_CYC);
    end
endmodule : crystal_source

// ### dv/tb_cpu_clock_generator_owd.sv
// self-checking bench of the cpu clock generator with oscillator watchdog
`timescale 1ns/10ps
`include "cpu_clock_generator_owd_params.svh"

module tb_cpu_clock_generator_owd;
    import cpu_clock_generator_owd_pkg::*;

    // ----
    // stimulus and observation
    // ----
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [2:0] straps = 3'h7;
    logic xtalRun = 1'b1;
    logic xtal;
    logic lock;
    logic owdOff = 1'b0;
    logic idle = 1'b0;
    logic pdown = 1'b0;
    clk_status_s st;
    logic irq;
    int error_cnt = 0;
    int cmp_count = 0;
    int irqCnt = 0;
    logic [4:0] halves [8] = '{`CCG_HALVES_X2P5, `CCG_HALVES_DIV2, `CCG_HALVES_X1P5,
        `CCG_HALVES_X1, `CCG_HALVES_X5, `CCG_HALVES_X2, `CCG_HALVES_X3, `CCG_HALVES_X4};

    initial begin
        forever #25 clk = ~clk;
    end

    crystal_source #(.HALF(10), .LOCK_CYC(8)) xo (
        .clk(clk),
        .run(xtalRun),
        .xtal(xtal),
        .lock(lock)
    );

    cpu_clock_generator_owd dut (
        .clk(clk),
        .reset_n(reset_n),
        .clockSelectStraps(straps),
        .crystalInputPin(xtal),
        .pllLockedRaw(lock),
        .oscWatchdogDisable(owdOff),
        .idleMode(idle),
        .powerDownMode(pdown),
        .clkStatus(st),
        .clockFailIrq(irq)
    );

    // counting pulses avoids racing a one-cycle output
    always @(posedge clk) begin
        if (irq === 1'b1) irqCnt <= irqCnt + 1;
    end

    // ----
    // helpers
    // ----
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // ends on a falling edge so outputs have settled
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : cyc

    // reset longer than the lock delay of the source
    task automatic doReset(input logic [2:0] code);
        @(posedge clk);
        reset_n <= 1'b0;
        straps <= code;
        xtalRun <= 1'b1;
        owdOff <= 1'b0;
        cyc(20);
        chk(8'(st.pllSyncAllow), 8'h01);
        @(posedge clk) reset_n <= 1'b1;
        cyc(1);
        chk(8'(st.pllSyncAllow), 8'h00);
    endtask : doReset

    // ----
    // scenarios
    // ----
    task automatic testStraps();
        logic [1:0] src;
        for (int c = 0; c < 8; c++) begin
            doReset(3'(c));
            src = (c == 3) ? SRC_DIRECT : (c == 1) ? SRC_PRESCALE : SRC_PLL;
            chk(8'(st.cpuSrc), 8'(src));
            chk(8'(st.factorHalves), 8'(halves[c]));
            // the watchdog is armed after reset, so the pll also runs in direct and prescaler modes
            chk(8'(st.pllOn), 8'h01);
            @(posedge clk) straps <= ~3'(c);
            cyc(6);
            chk(8'(st.factorHalves), 8'(halves[c]));
        end
    endtask : testStraps

    task automatic testTrip(input logic [2:0] code);
        int n0;
        doReset(code);
        n0 = irqCnt;
        cyc(200);
        chk(8'(irqCnt - n0), 8'h00);
        @(posedge clk) xtalRun <= 1'b0;
        cyc(60);
        chk(8'(irqCnt - n0), 8'h00);
        cyc(60);
        chk(8'(irqCnt - n0), 8'h01);
        chk(8'(st.cpuSrc), 8'(SRC_PLL_BASE));
        chk(8'(st.owdTripped), 8'h01);
        @(posedge clk) xtalRun <= 1'b1;
        cyc(100);
        chk(8'(st.cpuSrc), 8'(SRC_PLL_BASE));
        doReset(code);
        chk(8'(st.cpuSrc), 8'(code == 3'h3 ? SRC_DIRECT : SRC_PRESCALE));
    endtask : testTrip

    task automatic testLock();
        int n0;
        doReset(3'h7);
        cyc(10);
        chk(8'(st.pllAtBase), 8'h00);
        n0 = irqCnt;
        @(posedge clk) xtalRun <= 1'b0;
        cyc(8);
        chk(8'(irqCnt - n0), 8'h01);
        chk(8'(st.pllAtBase), 8'h01);
        cyc(150);
        chk(8'(irqCnt - n0), 8'h01);
        chk(8'(st.cpuSrc), 8'(SRC_PLL));
    endtask : testLock

    task automatic testDisable();
        int n0;
        doReset(3'h1);
        n0 = irqCnt;
        @(posedge clk) owdOff <= 1'b1;
        cyc(3);
        chk(8'(st.pllOn), 8'h00);
        chk(8'(st.cpuSrc), 8'(SRC_PRESCALE));
        @(posedge clk) xtalRun <= 1'b0;
        cyc(150);
        chk(8'(irqCnt - n0), 8'h00);
        chk(8'(st.owdTripped), 8'h00);
        @(posedge clk) owdOff <= 1'b0;
        cyc(120);
        chk(8'(st.owdTripped), 8'h01);
    endtask : testDisable

    task automatic testPower();
        doReset(3'h7);
        chk(8'({st.cpuClkRun, st.periphClkRun}), 8'h03);
        @(posedge clk) idle <= 1'b1;
        cyc(2);
        chk(8'({st.cpuClkRun, st.periphClkRun}), 8'h01);
        @(posedge clk) pdown <= 1'b1;
        cyc(2);
        chk(8'({st.cpuClkRun, st.periphClkRun}), 8'h00);
        @(posedge clk);
        idle <= 1'b0;
        pdown <= 1'b0;
        cyc(2);
        chk(8'({st.cpuClkRun, st.periphClkRun}), 8'h03);
    endtask : testPower

    task automatic summarize();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize

    // ----
    // sequence and watchdog
    // ----
    initial begin
        cyc(2);
        testStraps();
        testTrip(3'h3);
        testTrip(3'h1);
        testLock();
        testDisable();
        testPower();
        summarize();
    end

    // the whole run needs well under a fifth of this span
    initial begin
        #(50 * 20000);
        error_cnt++;
        summarize();
    end
endmodule : tb_cpu_clock_generator_owd
